//--- hw/call_return_branch_unit.sv
`timescale 1ns/100ps
module call_return_branch_unit #(
  parameter int MEM_ADDR_W = 8
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);

  typedef enum logic {
    PH_IDLE,
    PH_EXEC
  } phase_e;

  typedef struct packed {
    phase_e phase;
    flow_unit_pkg::op_e op;
    logic [15:0] operand;
    logic [3:0] step;
    logic [3:0] lastCycles;
    logic [15:0] pc;
    logic [15:0] sp;
    logic [7:0] flagWord;
    logic [15:0] accumulatorPair;
    logic [15:0] pairOperand;
    logic [15:0] memAddr;
    logic [2:0][7:0] readBytes;
    logic outOfRam;
    logic dataPhase;
    logic [7:0] dataAddr;
    logic dataWrite;
    logic readyOut;
    logic [31:0] readData;
  } state_s;

  state_s s_q;
  state_s s_d;

  logic wrEn;
  logic [15:0] wrAddr;
  logic [7:0] wrData;
  logic [15:0] rdAddr;
  logic [7:0] rdData;
  logic [15:0] returnAddr;
  logic [15:0] relTarget;
  logic [15:0] readBase;
  logic [2:0][7:0] writeBytes;
  logic [3:0] nWrites;
  logic [3:0] readStart;
  logic [3:0] nReads;
  logic [3:0] readIdx;
  logic [3:0] lastStep;
  logic taken;
  logic busy;

  assign busy = (s_q.phase == PH_EXEC);
  assign returnAddr = s_q.pc + flow_unit_pkg::opLength(s_q.op);
  // Two's-complement displacement, extended before the add
  assign relTarget = returnAddr + 16'(signed'(s_q.operand[7:0]));
  assign lastStep = flow_unit_pkg::opCycles(s_q.op) - 4'h1;
  assign readIdx = s_q.step - readStart;

  // Per-operation stack traffic: writes run from step 0, reads from readStart
  always_comb begin
    writeBytes = '0;
    nWrites = '0;
    readStart = '0;
    nReads = '0;
    readBase = s_q.sp;
    taken = 1'b0;
    unique case (s_q.op)
      flow_unit_pkg::OP_SUBROUTINE_CALL_ABS,
      flow_unit_pkg::OP_SHORT_PAGE_SUBROUTINE_JUMP: begin
        writeBytes[0] = returnAddr[15:8];
        writeBytes[1] = returnAddr[7:0];
        nWrites = 4'h2;
      end
      flow_unit_pkg::OP_VECTOR_TABLE_SUBROUTINE_JUMP: begin
        writeBytes[0] = returnAddr[15:8];
        writeBytes[1] = returnAddr[7:0];
        nWrites = 4'h2;
        readStart = 4'h2;
        nReads = 4'h2;
        readBase = {flow_unit_pkg::TABLE_PAGE, 8'(s_q.operand[4:0])};
      end
      flow_unit_pkg::OP_SOFTWARE_BREAK_TRAP: begin
        writeBytes[0] = s_q.flagWord;
        writeBytes[1] = returnAddr[15:8];
        writeBytes[2] = returnAddr[7:0];
        nWrites = 4'h3;
        readStart = 4'h3;
        nReads = 4'h2;
        readBase = flow_unit_pkg::TRAP_VECTOR;
      end
      flow_unit_pkg::OP_SUBROUTINE_RETURN: begin
        nReads = 4'h2;
      end
      flow_unit_pkg::OP_INTERRUPT_RETURN,
      flow_unit_pkg::OP_BREAK_RETURN: begin
        nReads = 4'h3;
      end
      flow_unit_pkg::OP_PUSH_FLAG_WORD: begin
        writeBytes[0] = s_q.flagWord;
        nWrites = 4'h1;
      end
      flow_unit_pkg::OP_PUSH_PAIR: begin
        writeBytes[0] = s_q.pairOperand[15:8];
        writeBytes[1] = s_q.pairOperand[7:0];
        nWrites = 4'h2;
      end
      flow_unit_pkg::OP_POP_FLAG_WORD: begin
        nReads = 4'h1;
      end
      flow_unit_pkg::OP_POP_PAIR: begin
        nReads = 4'h2;
      end
      flow_unit_pkg::OP_JUMP_IF_CARRY_SET: begin
        taken = s_q.flagWord[flow_unit_pkg::FLAG_CARRY];
      end
      flow_unit_pkg::OP_JUMP_IF_CARRY_CLEAR: begin
        taken = !s_q.flagWord[flow_unit_pkg::FLAG_CARRY];
      end
      flow_unit_pkg::OP_JUMP_IF_ZERO_SET: begin
        taken = s_q.flagWord[flow_unit_pkg::FLAG_ZERO];
      end
      flow_unit_pkg::OP_JUMP_IF_ZERO_CLEAR: begin
        taken = !s_q.flagWord[flow_unit_pkg::FLAG_ZERO];
      end
      default: begin
        taken = 1'b0;
      end
    endcase
  end

  always_comb begin
    s_d = s_q;
    wrEn = 1'b0;
    wrAddr = s_q.memAddr;
    wrData = '0;
    rdAddr = s_q.memAddr;

    // Instruction sequencer
    if (busy) begin
      if (s_q.step < nWrites) begin
        wrEn = 1'b1;
        // sp + ~step is sp - 1 - step: successive pushes go downward
        wrAddr = s_q.sp + ~{12'h000, s_q.step};
        wrData = writeBytes[s_q.step[1:0]];
        if (flow_unit_pkg::outsideFastRam(wrAddr)) begin
          s_d.outOfRam = 1'b1;
        end
      end
      if (s_q.step >= readStart && s_q.step < readStart + nReads) begin
        rdAddr = readBase + {12'h000, readIdx};
        if (flow_unit_pkg::outsideFastRam(rdAddr)) begin
          s_d.outOfRam = 1'b1;
        end
      end
      // Read data leave the memory register one step after the address
      if (s_q.step > readStart && s_q.step <= readStart + nReads) begin
        s_d.readBytes[readIdx[1:0] - 2'h1] = rdData;
      end
      if (s_q.step == lastStep) begin
        s_d.phase = PH_IDLE;
        s_d.lastCycles = flow_unit_pkg::opCycles(s_q.op);
        s_d.pc = returnAddr;
        unique case (s_q.op)
          flow_unit_pkg::OP_SUBROUTINE_CALL_ABS: begin
            s_d.pc = s_q.operand;
            s_d.sp = s_q.sp - {12'h000, nWrites};
          end
          flow_unit_pkg::OP_SHORT_PAGE_SUBROUTINE_JUMP: begin
            s_d.pc = {flow_unit_pkg::SHORT_PAGE_PREFIX, s_q.operand[10:0]};
            s_d.sp = s_q.sp - {12'h000, nWrites};
          end
          flow_unit_pkg::OP_VECTOR_TABLE_SUBROUTINE_JUMP: begin
            s_d.pc = {s_d.readBytes[1], s_d.readBytes[0]};
            s_d.sp = s_q.sp - {12'h000, nWrites};
          end
          flow_unit_pkg::OP_SOFTWARE_BREAK_TRAP: begin
            s_d.pc = {s_d.readBytes[1], s_d.readBytes[0]};
            s_d.sp = s_q.sp - {12'h000, nWrites};
            s_d.flagWord[flow_unit_pkg::FLAG_INT_ENABLE] = 1'b0;
          end
          flow_unit_pkg::OP_SUBROUTINE_RETURN: begin
            s_d.pc = {s_d.readBytes[1], s_d.readBytes[0]};
            s_d.sp = s_q.sp + {12'h000, nReads};
          end
          flow_unit_pkg::OP_INTERRUPT_RETURN,
          flow_unit_pkg::OP_BREAK_RETURN: begin
            s_d.pc = {s_d.readBytes[1], s_d.readBytes[0]};
            s_d.flagWord = s_d.readBytes[2];
            s_d.sp = s_q.sp + {12'h000, nReads};
          end
          flow_unit_pkg::OP_PUSH_FLAG_WORD,
          flow_unit_pkg::OP_PUSH_PAIR: begin
            s_d.sp = s_q.sp - {12'h000, nWrites};
          end
          flow_unit_pkg::OP_POP_FLAG_WORD: begin
            s_d.flagWord = s_d.readBytes[0];
            s_d.sp = s_q.sp + {12'h000, nReads};
          end
          flow_unit_pkg::OP_POP_PAIR: begin
            s_d.pairOperand = {s_d.readBytes[1], s_d.readBytes[0]};
            s_d.sp = s_q.sp + {12'h000, nReads};
          end
          flow_unit_pkg::OP_JUMP_ABS: begin
            s_d.pc = s_q.operand;
          end
          flow_unit_pkg::OP_JUMP_REL: begin
            s_d.pc = relTarget;
          end
          flow_unit_pkg::OP_JUMP_ACC_PAIR: begin
            s_d.pc = s_q.accumulatorPair;
          end
          default: begin
            s_d.pc = taken ? relTarget : returnAddr;
          end
        endcase
      end else begin
        s_d.step = s_q.step + 4'h1;
      end
    end

    // Bus slave: one wait state, then the write lands or read data appear
    if (s_q.dataPhase) begin
      s_d.dataPhase = 1'b0;
      s_d.readyOut = 1'b1;
      s_d.readData = '0;
      if (s_q.dataWrite) begin
        unique case (s_q.dataAddr)
          flow_unit_pkg::REG_CTRL: begin
            // A start with an unknown operation code is dropped
            if (!busy && hwdata[flow_unit_pkg::CTRL_START_BIT]
                && hwdata[flow_unit_pkg::CTRL_OP_LSB +: 5] < flow_unit_pkg::OP_COUNT) begin
              s_d.phase = PH_EXEC;
              s_d.op = flow_unit_pkg::op_e'(hwdata[flow_unit_pkg::CTRL_OP_LSB +: 5]);
              s_d.operand = hwdata[flow_unit_pkg::CTRL_OPERAND_LSB +: 16];
              s_d.step = '0;
              s_d.outOfRam = 1'b0;
              s_d.readBytes = '0;
            end
          end
          flow_unit_pkg::REG_PC: begin
            if (!busy) begin
              s_d.pc = hwdata[15:0];
            end
          end
          flow_unit_pkg::REG_SP: begin
            if (!busy) begin
              s_d.sp = hwdata[15:0];
            end
          end
          flow_unit_pkg::REG_FLAGS: begin
            if (!busy) begin
              s_d.flagWord = hwdata[7:0];
            end
          end
          flow_unit_pkg::REG_ACC_PAIR: begin
            if (!busy) begin
              s_d.accumulatorPair = hwdata[15:0];
            end
          end
          flow_unit_pkg::REG_PAIR: begin
            if (!busy) begin
              s_d.pairOperand = hwdata[15:0];
            end
          end
          flow_unit_pkg::REG_MEM_ADDR: begin
            s_d.memAddr = hwdata[15:0];
          end
          flow_unit_pkg::REG_MEM_DATA: begin
            // The sequencer owns the memory port while an operation runs
            if (!busy) begin
              wrEn = 1'b1;
              wrData = hwdata[7:0];
            end
          end
          default: begin
            s_d.readData = '0;
          end
        endcase
      end else begin
        unique case (s_q.dataAddr)
          flow_unit_pkg::REG_STATUS: begin
            s_d.readData[flow_unit_pkg::STATUS_BUSY_BIT] = busy;
            s_d.readData[flow_unit_pkg::STATUS_OUT_OF_RAM_BIT] = s_q.outOfRam;
            s_d.readData[flow_unit_pkg::STATUS_CYCLES_LSB +: 4] = s_q.lastCycles;
          end
          flow_unit_pkg::REG_PC: s_d.readData[15:0] = s_q.pc;
          flow_unit_pkg::REG_SP: s_d.readData[15:0] = s_q.sp;
          flow_unit_pkg::REG_FLAGS: s_d.readData[7:0] = s_q.flagWord;
          flow_unit_pkg::REG_ACC_PAIR: s_d.readData[15:0] = s_q.accumulatorPair;
          flow_unit_pkg::REG_PAIR: s_d.readData[15:0] = s_q.pairOperand;
          flow_unit_pkg::REG_MEM_ADDR: s_d.readData[15:0] = s_q.memAddr;
          flow_unit_pkg::REG_MEM_DATA: s_d.readData[7:0] = rdData;
          default: s_d.readData = '0;
        endcase
      end
    end
    if (hsel && htrans[1] && hready) begin
      s_d.dataPhase = 1'b1;
      s_d.dataAddr = haddr[7:0];
      s_d.dataWrite = hwrite;
      s_d.readyOut = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= '0;
      s_q.phase <= PH_IDLE;
      s_q.op <= flow_unit_pkg::OP_SUBROUTINE_CALL_ABS;
      s_q.pc <= flow_unit_pkg::PC_RESET;
      s_q.sp <= flow_unit_pkg::SP_RESET;
      s_q.flagWord <= flow_unit_pkg::FLAGS_RESET;
      s_q.readyOut <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  stack_byte_ram #(
    .ADDR_W(MEM_ADDR_W),
    .DATA_W(8)
  ) u_ram (
    .clk(clk),
    .srst(srst),
    .wrEn(wrEn),
    .wrAddr(wrAddr[MEM_ADDR_W-1:0]),
    .wrData(wrData),
    .rdAddr(rdAddr[MEM_ADDR_W-1:0]),
    .rdData(rdData)
  );

  assign hrdata = s_q.readData;
  assign hreadyout = s_q.readyOut;
  // Every transfer ends OKAY
  assign hresp = 1'b0;

endmodule

//--- hw/stack_byte_ram.sv
`timescale 1ns/100ps
module stack_byte_ram #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 8
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic wrEn,
  input wire logic [ADDR_W-1:0] wrAddr,
  input wire logic [DATA_W-1:0] wrData,
  input wire logic [ADDR_W-1:0] rdAddr,
  output logic [DATA_W-1:0] rdData
);

  typedef struct packed {
    logic [(1 << ADDR_W)-1:0][DATA_W-1:0] mem;
    logic [DATA_W-1:0] rdData;
  } ram_s;

  ram_s s_q;
  ram_s s_d;

  // Read before write: a read of the word being written returns the old byte
  always_comb begin
    s_d = s_q;
    s_d.rdData = s_q.mem[rdAddr];
    if (wrEn) begin
      s_d.mem[wrAddr] = wrData;
    end
  end

  // Contents are left alone by reset; only the read register is cleared
  always_ff @(posedge clk) begin
    s_q <= s_d;
    if (srst) begin
      s_q.rdData <= '0;
    end
  end

  assign rdData = s_q.rdData;

endmodule

//--- inc/flow_unit_pkg.sv
package flow_unit_pkg;

  // Operations carried out by the unit, selected through the control register
  typedef enum logic [4:0] {
    OP_SUBROUTINE_CALL_ABS,
    OP_SHORT_PAGE_SUBROUTINE_JUMP,
    OP_VECTOR_TABLE_SUBROUTINE_JUMP,
    OP_SOFTWARE_BREAK_TRAP,
    OP_SUBROUTINE_RETURN,
    OP_INTERRUPT_RETURN,
    OP_BREAK_RETURN,
    OP_PUSH_FLAG_WORD,
    OP_PUSH_PAIR,
    OP_POP_FLAG_WORD,
    OP_POP_PAIR,
    OP_JUMP_ABS,
    OP_JUMP_REL,
    OP_JUMP_ACC_PAIR,
    OP_JUMP_IF_CARRY_SET,
    OP_JUMP_IF_CARRY_CLEAR,
    OP_JUMP_IF_ZERO_SET,
    OP_JUMP_IF_ZERO_CLEAR
  } op_e;

  localparam logic [4:0] OP_COUNT = 5'h12;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_PC = 8'h08;
  localparam logic [7:0] REG_SP = 8'h0c;
  localparam logic [7:0] REG_FLAGS = 8'h10;
  localparam logic [7:0] REG_ACC_PAIR = 8'h14;
  localparam logic [7:0] REG_PAIR = 8'h18;
  localparam logic [7:0] REG_MEM_ADDR = 8'h1c;
  localparam logic [7:0] REG_MEM_DATA = 8'h20;

  // Field positions
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_OP_LSB = 8;
  localparam int CTRL_OPERAND_LSB = 16;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_OUT_OF_RAM_BIT = 1;
  localparam int STATUS_CYCLES_LSB = 8;
  localparam int FLAG_CARRY = 0;
  localparam int FLAG_AUX_CARRY = 4;
  localparam int FLAG_ZERO = 6;
  localparam int FLAG_INT_ENABLE = 7;

  // Reset values
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] SP_RESET = 16'h0000;
  localparam logic [7:0] FLAGS_RESET = 8'h00;

  // Fixed addresses
  localparam logic [4:0] SHORT_PAGE_PREFIX = 5'h01;
  localparam logic [7:0] TABLE_PAGE = 8'h00;
  localparam logic [15:0] TRAP_VECTOR = 16'h003e;
  localparam logic [15:0] FAST_RAM_FIRST = 16'h0000;
  localparam logic [15:0] FAST_RAM_LAST = 16'h00ff;

  // Instruction lengths in bytes and clock counts
  localparam logic [15:0] LEN_ONE = 16'h0001;
  localparam logic [15:0] LEN_TWO = 16'h0002;
  localparam logic [15:0] LEN_THREE = 16'h0003;
  localparam logic [3:0] CYC_CALL_ABS = 4'h7;
  localparam logic [3:0] CYC_SHORT_CALL = 4'h5;
  localparam logic [3:0] CYC_SIX = 4'h6;
  localparam logic [3:0] CYC_FLAG_STACK = 4'h2;
  localparam logic [3:0] CYC_PAIR_STACK = 4'h4;
  localparam logic [3:0] CYC_JUMP_ACC = 4'h8;

  function automatic logic [15:0] opLength(input op_e op);
    unique case (op)
      OP_SUBROUTINE_CALL_ABS, OP_JUMP_ABS: opLength = LEN_THREE;
      OP_SHORT_PAGE_SUBROUTINE_JUMP, OP_JUMP_REL, OP_JUMP_ACC_PAIR,
      OP_JUMP_IF_CARRY_SET, OP_JUMP_IF_CARRY_CLEAR,
      OP_JUMP_IF_ZERO_SET, OP_JUMP_IF_ZERO_CLEAR: opLength = LEN_TWO;
      default: opLength = LEN_ONE;
    endcase
  endfunction

  // Only the fast-RAM column exists for these operations
  function automatic logic [3:0] opCycles(input op_e op);
    unique case (op)
      OP_SUBROUTINE_CALL_ABS: opCycles = CYC_CALL_ABS;
      OP_SHORT_PAGE_SUBROUTINE_JUMP: opCycles = CYC_SHORT_CALL;
      OP_PUSH_FLAG_WORD, OP_POP_FLAG_WORD: opCycles = CYC_FLAG_STACK;
      OP_PUSH_PAIR, OP_POP_PAIR: opCycles = CYC_PAIR_STACK;
      OP_JUMP_ACC_PAIR: opCycles = CYC_JUMP_ACC;
      default: opCycles = CYC_SIX;
    endcase
  endfunction

  function automatic logic outsideFastRam(input logic [15:0] addr);
    outsideFastRam = (addr < FAST_RAM_FIRST) || (addr > FAST_RAM_LAST);
  endfunction

endpackage

//--- tb/flow_unit_checker.sv
`timescale 1ns/100ps
module flow_unit_checker #(
  parameter int MEM_ADDR_W = 8
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp
);
  logic take;
  logic dataEdge;
  logic stLoad;
  logic ctrlStart;
  logic phase_q;
  logic phWrite_q;
  logic [7:0] phAddr_q;
  logic [4:0] cnt_q;
  logic [3:0] lastN_q;
  logic [4:0] lastOp_q;

  // Own clock table, so a slip in the design's table is not copied here
  function automatic logic [3:0] cycFor(input logic [4:0] op);
    case (op)
      5'h00: cycFor = 4'h7;
      5'h01: cycFor = 4'h5;
      5'h07, 5'h09: cycFor = 4'h2;
      5'h08, 5'h0a: cycFor = 4'h4;
      5'h0d: cycFor = 4'h8;
      default: cycFor = 4'h6;
    endcase
  endfunction

  assign take = hsel && htrans[1] && hready;
  assign dataEdge = phase_q && !hreadyout;
  assign stLoad = dataEdge && !phWrite_q && phAddr_q == flow_unit_pkg::REG_STATUS;
  assign ctrlStart = dataEdge && phWrite_q && phAddr_q == flow_unit_pkg::REG_CTRL && hwdata[0]
    && hwdata[12:8] < flow_unit_pkg::OP_COUNT && cnt_q == 5'h00;

  always_ff @(posedge clk) begin
    if (srst) begin
      phase_q <= 1'b0;
      phWrite_q <= 1'b0;
      phAddr_q <= 8'h00;
      cnt_q <= 5'h00;
      lastN_q <= 4'h0;
      lastOp_q <= 5'h1f;
    end else begin
      if (take) begin
        phase_q <= 1'b1;
        phWrite_q <= hwrite;
        phAddr_q <= haddr[7:0];
      end else if (!hreadyout) begin
        phase_q <= 1'b0;
      end
      // Two spare counts keep the busy checks clear of the exact release edge
      if (ctrlStart) begin
        cnt_q <= {1'b0, cycFor(hwdata[12:8])} + 5'h02;
        lastN_q <= cycFor(hwdata[12:8]);
        lastOp_q <= hwdata[12:8];
      end else if (cnt_q != 5'h00) begin
        cnt_q <= cnt_q - 5'h01;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  okay_resp_a: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  wait_state_a: assert property (take |=> !hreadyout ##1 hreadyout)
    else $error("data phase not exactly one wait cycle");
  ready_idle_a: assert property (!phase_q |-> hreadyout)
    else $error("ready low outside a data phase");
  hold_rdata_a: assert property (hreadyout |=> $stable(hrdata))
    else $error("read data changed outside its load edge");
  busy_set_a: assert property (stLoad && cnt_q >= 5'h04 && cnt_q <= lastN_q + 5'h01 |=> hrdata[0])
    else $error("busy low before the operation count ran out");
  busy_clear_a: assert property (stLoad && cnt_q <= 5'h01 |=> !hrdata[0])
    else $error("busy still high after the operation count");
  // Counts of two or less are past the release edge, so the final count already stands
  call_cycles_a: assert property (stLoad && cnt_q <= 5'h02 && lastOp_q <= 5'h03
    |=> hrdata[11:8] == lastN_q) else $error("call clock count wrong");
  ret_cycles_a: assert property (stLoad && cnt_q <= 5'h02 && lastOp_q inside {[5'h04:5'h06]}
    |=> hrdata[11:8] == lastN_q) else $error("return clock count wrong");
  stack_cycles_a: assert property (stLoad && cnt_q <= 5'h02 && lastOp_q inside {[5'h07:5'h0a]}
    |=> hrdata[11:8] == lastN_q) else $error("stack clock count wrong");
  jump_cycles_a: assert property (stLoad && cnt_q <= 5'h02 && lastOp_q inside {[5'h0c:5'h11]}
    |=> hrdata[11:8] == lastN_q) else $error("jump clock count wrong");

  trap_start_c: cover property (ctrlStart && hwdata[12:8] == 5'h03);
  busy_read_c: cover property (stLoad && cnt_q >= 5'h04);
  pc_read_c: cover property (take && !hwrite && haddr[7:0] == flow_unit_pkg::REG_PC);
endmodule

//--- tb/stack_ram_model.sv
`timescale 1ns/100ps
module stack_ram_model;
  logic [7:0] mem [256];
  // Filler differs per address, so a byte taken from the wrong place shows up
  initial begin
    foreach (mem[i]) begin
      mem[i] = 8'(i) ^ 8'h5a;
    end
    mem[8'h10] = 8'h78;
    mem[8'h11] = 8'h56;
    mem[8'h3e] = 8'hbc;
    mem[8'h3f] = 8'h9a;
    mem[8'h80] = 8'hd1;
    mem[8'h81] = 8'h12;
    mem[8'h82] = 8'h51;
  end
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    mem[a] = d;
  endtask
endmodule

//--- tb/testbench.sv
`timescale 1ns/100ps
module testbench;
  typedef struct packed {
    logic [4:0] op;
    logic [15:0] opd;
    logic [7:0] fl;
    logic [15:0] pc;
    logic [15:0] sp;
    logic [7:0] efl;
    logic [1:0] n;
    logic [23:0] pb;
  } row_s;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic hsel = 1'b1;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [31:0] r;
  int failCount = 0;
  int checkCount = 0;
  // The table call reads its target from the page-zero word at the bare 5-bit index
  logic [7:0] pre [10] = '{8'h10, 8'h11, 8'h3e, 8'h3f, 8'h7d, 8'h7e, 8'h7f, 8'h80, 8'h81, 8'h82};
  // Each op starts at PC 1000, SP 0080; n bytes land from SP-1 downwards
  row_s rows [21] = '{
    '{5'h00,16'h4321,8'h00,16'h4321,16'h007e,8'h00,2'h2,24'h00_0310},
    '{5'h01,16'hffff,8'h00,16'h0fff,16'h007e,8'h00,2'h2,24'h00_0210},
    '{5'h02,16'h0010,8'h00,16'h5678,16'h007e,8'h00,2'h2,24'h00_0110},
    '{5'h03,16'h0000,8'h81,16'h9abc,16'h007d,8'h01,2'h3,24'h01_1081},
    '{5'h04,16'h0000,8'h00,16'h12d1,16'h0082,8'h00,2'h0,24'h00_0000},
    '{5'h05,16'h0000,8'h00,16'h12d1,16'h0083,8'h51,2'h0,24'h00_0000},
    '{5'h06,16'h0000,8'h00,16'h12d1,16'h0083,8'h51,2'h0,24'h00_0000},
    '{5'h07,16'h0000,8'h45,16'h1001,16'h007f,8'h45,2'h1,24'h00_0045},
    '{5'h08,16'h0000,8'h00,16'h1001,16'h007e,8'h00,2'h2,24'h00_6824},
    '{5'h09,16'h0000,8'h00,16'h1001,16'h0081,8'hd1,2'h0,24'h00_0000},
    '{5'h0a,16'h0000,8'h00,16'h1001,16'h0082,8'h00,2'h0,24'h00_0000},
    '{5'h0b,16'hbeef,8'h00,16'hbeef,16'h0080,8'h00,2'h0,24'h00_0000},
    '{5'h0c,16'h0080,8'h00,16'h0f82,16'h0080,8'h00,2'h0,24'h00_0000},
    '{5'h0c,16'h007f,8'h00,16'h1081,16'h0080,8'h00,2'h0,24'h00_0000},
    '{5'h0d,16'h0000,8'h00,16'ha55a,16'h0080,8'h00,2'h0,24'h00_0000},
    '{5'h0e,16'h0010,8'h01,16'h1012,16'h0080,8'h01,2'h0,24'h00_0000},
    '{5'h0e,16'h0010,8'h00,16'h1002,16'h0080,8'h00,2'h0,24'h00_0000},
    '{5'h0f,16'hfff0,8'h00,16'h0ff2,16'h0080,8'h00,2'h0,24'h00_0000},
    '{5'h0f,16'hfff0,8'h01,16'h1002,16'h0080,8'h01,2'h0,24'h00_0000},
    '{5'h10,16'h0004,8'h40,16'h1006,16'h0080,8'h40,2'h0,24'h00_0000},
    '{5'h11,16'h0004,8'h40,16'h1002,16'h0080,8'h40,2'h0,24'h00_0000}
  };

  stack_ram_model stack_ram_model_i ();

  call_return_branch_unit #(.MEM_ADDR_W(8)) call_return_branch_unit_i (
    .clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp)
  );

  always #2 clk = ~clk;

  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    htrans <= 2'b10;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      failCount++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic runOp(input logic [4:0] op, input logic [15:0] opd);
    xfer(flow_unit_pkg::REG_CTRL, 1'b1, {opd, 3'b000, op, 8'h01});
    r = 32'h0000_0001;
    while (r[0] !== 1'b0) xfer(flow_unit_pkg::REG_STATUS, 1'b0, 32'h0000_0000);
  endtask

  task automatic memRead(input logic [7:0] a);
    xfer(flow_unit_pkg::REG_MEM_ADDR, 1'b1, {24'h00_0000, a});
    xfer(flow_unit_pkg::REG_MEM_DATA, 1'b0, 32'h0000_0000);
  endtask

  task automatic finishTest();
    $display("checks %0d mismatches %0d", checkCount, failCount);
    if (failCount == 0 && checkCount > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    failCount++;
    finishTest();
  end

  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    for (int a = 4; a < 32; a += 4) begin
      xfer(8'(a), 1'b0, 32'h0000_0000);
      check("reset value", r, 32'h0000_0000);
    end
    xfer(flow_unit_pkg::REG_ACC_PAIR, 1'b1, 32'h0000_a55a);
    xfer(flow_unit_pkg::REG_PAIR, 1'b1, 32'h0000_2468);
    foreach (pre[i]) begin
      xfer(flow_unit_pkg::REG_MEM_ADDR, 1'b1, {24'h00_0000, pre[i]});
      xfer(flow_unit_pkg::REG_MEM_DATA, 1'b1, {24'h00_0000, stack_ram_model_i.mem[pre[i]]});
    end
    foreach (rows[i]) begin
      xfer(flow_unit_pkg::REG_PC, 1'b1, 32'h0000_1000);
      xfer(flow_unit_pkg::REG_SP, 1'b1, 32'h0000_0080);
      xfer(flow_unit_pkg::REG_FLAGS, 1'b1, {24'h00_0000, rows[i].fl});
      runOp(rows[i].op, rows[i].opd);
      xfer(flow_unit_pkg::REG_PC, 1'b0, 32'h0000_0000);
      check("pc", r, {16'h0000, rows[i].pc});
      xfer(flow_unit_pkg::REG_SP, 1'b0, 32'h0000_0000);
      check("sp", r, {16'h0000, rows[i].sp});
      xfer(flow_unit_pkg::REG_FLAGS, 1'b0, 32'h0000_0000);
      check("flags", r, {24'h00_0000, rows[i].efl});
      for (int k = 0; k < rows[i].n; k++) begin
        stack_ram_model_i.put(8'h7f - 8'(k), rows[i].pb[8*k +: 8]);
      end
      for (int k = 1; k < 4; k++) begin
        memRead(8'h80 - 8'(k));
        check("stack byte", r, {24'h00_0000, stack_ram_model_i.mem[8'h80 - 8'(k)]});
      end
    end
    xfer(flow_unit_pkg::REG_PAIR, 1'b0, 32'h0000_0000);
    check("pair", r, 32'h0000_12d1);
    // Start and flag writes during a call must be dropped
    xfer(flow_unit_pkg::REG_PC, 1'b1, 32'h0000_1000);
    xfer(flow_unit_pkg::REG_SP, 1'b1, 32'h0000_0080);
    xfer(flow_unit_pkg::REG_FLAGS, 1'b1, 32'h0000_0000);
    xfer(flow_unit_pkg::REG_CTRL, 1'b1, 32'h4321_0001);
    xfer(flow_unit_pkg::REG_CTRL, 1'b1, 32'h7777_0b01);
    xfer(flow_unit_pkg::REG_FLAGS, 1'b1, 32'h0000_00ff);
    runOp(5'h12, 16'h0000);
    check("status ram", {31'h0000_0000, r[1]}, 32'h0000_0000);
    xfer(flow_unit_pkg::REG_PC, 1'b0, 32'h0000_0000);
    check("pc busy", r, 32'h0000_4321);
    xfer(flow_unit_pkg::REG_FLAGS, 1'b0, 32'h0000_0000);
    check("flags busy", r, 32'h0000_0000);
    xfer(8'h40, 1'b1, 32'hffff_ffff);
    xfer(8'h40, 1'b0, 32'h0000_0000);
    check("unmapped", r, 32'h0000_0000);
    xfer(flow_unit_pkg::REG_SP, 1'b1, 32'h0000_0200);
    runOp(5'h07, 16'h0000);
    check("status far", {31'h0000_0000, r[1]}, 32'h0000_0001);
    // Reset lands while a slow jump is still running
    xfer(flow_unit_pkg::REG_CTRL, 1'b1, 32'h0000_0d01);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    xfer(flow_unit_pkg::REG_PC, 1'b0, 32'h0000_0000);
    check("pc after reset", r, 32'h0000_0000);
    finishTest();
  end
endmodule

bind call_return_branch_unit flow_unit_checker #(.MEM_ADDR_W(MEM_ADDR_W)) flow_unit_checker_i (
  .clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp)
);
